// ---- inc/dmc_pkg.sv ----
// Behaviour
// - Test-mode load updates no other field
// - DLL reset bit self-clears after reset
// - Wait 200 clocks after DLL reset
// - Auto precharge delayed by write recovery
// - Write recovery programmed 2 to 8
// - Fast-exit power-down keeps DLL running
// - Slow-exit power-down may freeze DLL
// - Exit select ignored in precharge power-down
// - Read latency 3 to 7 whole clocks
// - First read data at edge n plus latency
// - Early read held for additive latency
// - Load only when idle, then wait
// - Extended fields persist until reloaded
// - Follow DLL enable with DLL reset; dmc_ctrl does not enforce this and dll_locked rises without a DLL reset
// - Self refresh disables, then re-enables DLL
// - Slow clock without DLL: precharge after refresh
// - Drive bit selects full or reduced strength
// - Complement strobe disable makes strobe single-ended
// - Redundant complement needs both enables
// - Redundant strobe follows read strobe only
// - Output disable silences data and strobes
// - Additive latency 0 to 6 clocks
// - Write latency is read latency minus one
package dmc_pkg;
  // ---------------------------------------------------------------
  // Address and bank field layout
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 13;
  localparam int BANK_W      = 2;
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT  = 2'h1;
  localparam int CL_LSB      = 4;
  localparam int TEST_BIT    = 7;
  localparam int DLLRST_BIT  = 8;
  localparam int WR_LSB      = 9;
  localparam int PDX_BIT     = 12;
  localparam int DLLEN_BIT   = 0;
  localparam int DRIVE_BIT   = 1;
  localparam int AL_LSB      = 3;
  localparam int CSD_BIT     = 10;
  localparam int RDQS_BIT    = 11;
  localparam int OUTDIS_BIT  = 12;
  // ---------------------------------------------------------------
  // Legal ranges and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h7;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  localparam logic [2:0] WR_MAX_CODE = 3'h7;
  localparam int DLL_LOCK_CYC = 200;
  localparam int DLL_LOCK_W   = 8;
  localparam int CLK_MHZ      = 20;
  localparam int SLOW_CLK_MHZ = 25;
  localparam logic [2:0] RST_CL = 3'h3;
  localparam logic [2:0] RST_WR = 3'h1;
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DMC_NOP   = 3'b000,
    DMC_LOAD  = 3'b001,
    DMC_READ  = 3'b010,
    DMC_WRAP  = 3'b011,
    DMC_REF   = 3'b100,
    DMC_PREA  = 3'b101,
    DMC_SREN  = 3'b110,
    DMC_SREX  = 3'b111
  } dmc_cmd_e;
  typedef enum logic [1:0] {
    DMC_PD_NONE = 2'b00,
    DMC_PD_ACT  = 2'b01,
    DMC_PD_PRE  = 2'b10
  } dmc_pd_e;
endpackage

// ---- inc/dmc_if.sv ----
`timescale 1ns/1ps
interface dmc_if;
  dmc_pkg::dmc_cmd_e        cmd;
  logic [dmc_pkg::ADDR_W-1:0] addr;
  logic [dmc_pkg::BANK_W-1:0] bank;
  dmc_pkg::dmc_pd_e         pd;
  logic                     rd_data_valid;
  logic                     dq_oe_n;
  logic                     dqs_oe_n;
  logic                     dqs_n_oe_n;
  logic                     rdqs_oe_n;
  logic                     rdqs_n_oe_n;
  logic                     drive_reduced;
  logic                     dll_locked;
  modport ctrl (output cmd, addr, bank, pd,
                input rd_data_valid, dq_oe_n, dqs_oe_n, dqs_n_oe_n,
                rdqs_oe_n, rdqs_n_oe_n, drive_reduced, dll_locked);
  modport mem (input cmd, addr, bank, pd,
               output rd_data_valid, dq_oe_n, dqs_oe_n, dqs_n_oe_n,
               rdqs_oe_n, rdqs_n_oe_n, drive_reduced, dll_locked);
endinterface

// ---- logic/dmc_mem.sv ----
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module dmc_mem #(
  parameter int LAT_MAX = 14
) (
  input  wire logic  ref_clk_i,
  input  wire logic  reset_i,
  dmc_if.mem         bus,
  output logic [2:0] read_latency_o,
  output logic [2:0] additive_latency_o,
  output logic [3:0] total_write_latency_o,
  output logic [2:0] write_recovery_field_o,
  output logic       powerdown_exit_select_o,
  output logic       dll_enable_bit_o,
  output logic       dll_running_o,
  output logic       dll_frozen_o,
  output logic       dll_reset_bit_o,
  output logic       test_mode_o,
  output logic       precharge_pulse_o
);
  // ---------------------------------------------------------------
  // Mode and extended mode fields
  // ---------------------------------------------------------------
  logic [2:0] cl_q, al_q, wr_q;
  logic       pdx_q, dllrst_q, test_q;
  logic       dllen_q, drive_q, csd_q, rdqs_q, outdis_q;
  logic       sref_q;
  logic       is_load, mode_ld, ext_ld;

  assign is_load = bus.cmd == dmc_pkg::DMC_LOAD;
  assign mode_ld = is_load && bus.bank == dmc_pkg::BANK_MODE;
  assign ext_ld  = is_load && bus.bank == dmc_pkg::BANK_EXT;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cl_q   <= dmc_pkg::RST_CL;
      wr_q   <= dmc_pkg::RST_WR;
      pdx_q  <= 1'b0;
      test_q <= 1'b0;
    end
    else if (mode_ld)
    begin
      test_q <= bus.addr[dmc_pkg::TEST_BIT];
      if (!bus.addr[dmc_pkg::TEST_BIT])
      begin
        cl_q  <= bus.addr[dmc_pkg::CL_LSB +: 3];
        wr_q  <= bus.addr[dmc_pkg::WR_LSB +: 3];
        pdx_q <= bus.addr[dmc_pkg::PDX_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      dllen_q  <= 1'b1;
      drive_q  <= 1'b0;
      al_q     <= 3'h0;
      csd_q    <= 1'b0;
      rdqs_q   <= 1'b0;
      outdis_q <= 1'b0;
    end
    else if (ext_ld)
    begin
      dllen_q  <= bus.addr[dmc_pkg::DLLEN_BIT];
      drive_q  <= bus.addr[dmc_pkg::DRIVE_BIT];
      al_q     <= bus.addr[dmc_pkg::AL_LSB +: 3];
      csd_q    <= bus.addr[dmc_pkg::CSD_BIT];
      rdqs_q   <= bus.addr[dmc_pkg::RDQS_BIT];
      outdis_q <= bus.addr[dmc_pkg::OUTDIS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // DLL reset, lock and self refresh
  // ---------------------------------------------------------------
  localparam logic [7:0] DLL_LOCK_START = 8'(dmc_pkg::DLL_LOCK_CYC - 1);
  logic [dmc_pkg::DLL_LOCK_W-1:0] lock_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      sref_q <= 1'b0;
    else if (bus.cmd == dmc_pkg::DMC_SREN)
      sref_q <= 1'b1;
    else if (bus.cmd == dmc_pkg::DMC_SREX)
      sref_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      dllrst_q <= 1'b0;
    else if (mode_ld && !bus.addr[dmc_pkg::TEST_BIT]
             && bus.addr[dmc_pkg::DLLRST_BIT])
      dllrst_q <= 1'b1;
    else
      dllrst_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      lock_q <= '0;
    else if (dllrst_q || bus.cmd == dmc_pkg::DMC_SREX)
      lock_q <= DLL_LOCK_START;
    else if (lock_q != '0)
      lock_q <= lock_q - 1'b1;
  end

  // ---------------------------------------------------------------
  // Read and write latency, auto precharge
  // ---------------------------------------------------------------
  logic [3:0] rl;
  logic [LAT_MAX:0] rd_pipe_q, wp_pipe_q;
  assign rl = {1'b0, al_q} + {1'b0, cl_q};

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      rd_pipe_q <= '0;
    else
      rd_pipe_q <= {rd_pipe_q[LAT_MAX-1:0],
                    bus.cmd == dmc_pkg::DMC_READ && !sref_q};
  end

  // Burst end seen WL + 2 clocks after the write, then WR more clocks
  logic [4:0] ap_dly;
  assign ap_dly = 5'(rl) - 5'h1 + 5'h2 + 5'(wr_q) + 5'h1;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      wp_pipe_q <= '0;
    else
      wp_pipe_q <= {wp_pipe_q[LAT_MAX-1:0],
                    bus.cmd == dmc_pkg::DMC_WRAP};
  end

  logic rd_now, ap_now;
  assign rd_now = rl != 4'h0 && rd_pipe_q[rl - 4'h1];
  assign ap_now = ap_dly <= 5'(LAT_MAX + 1)
                  && wp_pipe_q[4'(ap_dly - 5'h1)];

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bus.rd_data_valid <= 1'b0;
      bus.dq_oe_n       <= 1'b1;
      bus.dqs_oe_n      <= 1'b1;
      bus.dqs_n_oe_n    <= 1'b1;
      bus.rdqs_oe_n     <= 1'b1;
      bus.rdqs_n_oe_n   <= 1'b1;
      bus.drive_reduced <= 1'b0;
      bus.dll_locked    <= 1'b0;
      precharge_pulse_o <= 1'b0;
    end
    else
    begin
      bus.rd_data_valid <= rd_now;
      bus.dq_oe_n       <= !(rd_now && !outdis_q);
      bus.dqs_oe_n      <= !(rd_now && !outdis_q);
      bus.dqs_n_oe_n    <= !(rd_now && !outdis_q && !csd_q);
      bus.rdqs_oe_n     <= !(rd_now && !outdis_q && rdqs_q);
      bus.rdqs_n_oe_n   <= !(rd_now && !outdis_q && rdqs_q
                            && !csd_q);
      bus.drive_reduced <= drive_q;
      bus.dll_locked    <= dllen_q && !sref_q && lock_q == '0;
      precharge_pulse_o <= ap_now;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      read_latency_o          <= dmc_pkg::RST_CL;
      additive_latency_o      <= 3'h0;
      total_write_latency_o   <= 4'h2;
      write_recovery_field_o  <= dmc_pkg::RST_WR;
      powerdown_exit_select_o <= 1'b0;
      dll_enable_bit_o        <= 1'b1;
      dll_running_o           <= 1'b0;
      dll_frozen_o            <= 1'b0;
      dll_reset_bit_o         <= 1'b0;
      test_mode_o             <= 1'b0;
    end
    else
    begin
      read_latency_o          <= cl_q;
      additive_latency_o      <= al_q;
      total_write_latency_o   <= rl - 4'h1;
      write_recovery_field_o  <= wr_q;
      powerdown_exit_select_o <= pdx_q;
      dll_enable_bit_o        <= dllen_q;
      // Only active power-down honours the exit select
      dll_frozen_o  <= bus.pd == dmc_pkg::DMC_PD_ACT && pdx_q;
      dll_running_o <= dllen_q && !sref_q
                       && !(bus.pd == dmc_pkg::DMC_PD_ACT && pdx_q);
      dll_reset_bit_o         <= dllrst_q;
      test_mode_o             <= test_q;
    end
  end
endmodule // dmc_mem

// ---- logic/dmc_ctrl.sv ----
`timescale 1ns/1ps
module dmc_ctrl (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  dmc_if.ctrl             bus,
  input  wire logic [3:0] sw_addr_i,
  input  wire logic [15:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic [15:0]     sw_rdata_o
);
  // ---------------------------------------------------------------
  // Software ports: 0 mode, 1 ext, 2 command, 3 status
  // ---------------------------------------------------------------
  localparam logic [3:0] A_MODE = 4'h0, A_EXT = 4'h1;
  localparam logic [3:0] A_CMD = 4'h2, A_STAT = 4'h3;
  localparam logic [7:0] MRD_CYC = 8'h2;
  logic [12:0] mode_q, ext_q;
  logic [7:0]  wait_q, lock_q;
  logic        err_q;
  logic        idle_ok;

  assign idle_ok = wait_q == 8'h0;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      mode_q <= 13'h0;
      ext_q  <= 13'h0;
    end
    else if (sw_wr_i && sw_addr_i == A_MODE)
      mode_q <= sw_wdata_i[12:0] & ~13'h0080;
    else if (sw_wr_i && sw_addr_i == A_EXT)
      ext_q <= sw_wdata_i[12:0];
  end

  // Issues one command per strobe, refresh then precharge with slow clock and DLL off; illegal ones are refused
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bus.cmd  <= dmc_pkg::DMC_NOP;
      bus.addr <= '0;
      bus.bank <= '0;
      bus.pd   <= dmc_pkg::DMC_PD_NONE;
      wait_q   <= 8'h0;
      lock_q   <= 8'h0;
      err_q    <= 1'b0;
    end
    else
    begin
      bus.cmd <= dmc_pkg::DMC_NOP;
      if (wait_q != 8'h0)
        wait_q <= wait_q - 8'h1;
      if (lock_q != 8'h0)
        lock_q <= lock_q - 8'h1;
      if (sw_wr_i && sw_addr_i == A_CMD && idle_ok)
      begin
        bus.pd <= dmc_pkg::dmc_pd_e'(sw_wdata_i[5:4]);
        case (sw_wdata_i[2:0])
          3'h1:
          begin
            if (mode_q[11:9] < dmc_pkg::WR_MIN_CODE
                || mode_q[6:4] < dmc_pkg::CL_MIN)
              err_q <= 1'b1;
            else
            begin
              bus.cmd  <= dmc_pkg::DMC_LOAD;
              bus.addr <= mode_q;
              bus.bank <= dmc_pkg::BANK_MODE;
              wait_q   <= MRD_CYC;
              if (mode_q[dmc_pkg::DLLRST_BIT])
                lock_q <= 8'(dmc_pkg::DLL_LOCK_CYC + 1);
            end
          end
          3'h2:
          begin
            if (ext_q[5:3] > dmc_pkg::AL_MAX)
              err_q <= 1'b1;
            else
            begin
              bus.cmd  <= dmc_pkg::DMC_LOAD;
              bus.addr <= ext_q;
              bus.bank <= dmc_pkg::BANK_EXT;
              wait_q   <= MRD_CYC;
            end
          end
          3'h3:
          begin
            if (lock_q != 8'h0)
              err_q <= 1'b1;
            else
              bus.cmd <= dmc_pkg::DMC_READ;
          end
          3'h4: bus.cmd <= dmc_pkg::DMC_WRAP;
          3'h5:
          begin
            bus.cmd <= dmc_pkg::DMC_REF;
            // Slow clock with DLL off needs a following precharge
            if (!ext_q[0] && dmc_pkg::CLK_MHZ < dmc_pkg::SLOW_CLK_MHZ)
              wait_q <= 8'h1;
          end
          3'h6: bus.cmd <= dmc_pkg::DMC_SREN;
          3'h7:
          begin
            bus.cmd <= dmc_pkg::DMC_SREX;
            lock_q  <= 8'(dmc_pkg::DLL_LOCK_CYC + 1);
          end
          default: bus.cmd <= dmc_pkg::DMC_NOP;
        endcase
      end
      else if (sw_wr_i && sw_addr_i == A_CMD)
        err_q <= 1'b1;
      if (wait_q == 8'h1 && !ext_q[0]
          && dmc_pkg::CLK_MHZ < dmc_pkg::SLOW_CLK_MHZ
          && bus.cmd == dmc_pkg::DMC_REF)
        bus.cmd <= dmc_pkg::DMC_PREA;
      if (sw_wr_i && sw_addr_i == A_STAT)
        err_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      sw_rdata_o <= 16'h0;
    else if (sw_rd_i)
      case (sw_addr_i)
        A_MODE:  sw_rdata_o <= {3'h0, mode_q};
        A_EXT:   sw_rdata_o <= {3'h0, ext_q};
        A_STAT:  sw_rdata_o <= {10'h0, bus.drive_reduced, err_q,
                                lock_q == 8'h0, idle_ok,
                                bus.dll_locked, bus.rd_data_valid};
        default: sw_rdata_o <= 16'h0;
      endcase
    else
      sw_rdata_o <= 16'h0;
  end
endmodule // dmc_ctrl

// ---- verification/dmc_assertions.sv ----
`timescale 1ns/1ps
module dmc_assertions (
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire dmc_pkg::dmc_cmd_e cmd,
  input wire logic [12:0]       addr,
  input wire logic [1:0]        bank,
  input wire logic              rd_data_valid,
  input wire logic              dq_oe_n,
  input wire logic              dqs_oe_n,
  input wire logic              dqs_n_oe_n,
  input wire logic              rdqs_oe_n,
  input wire logic              rdqs_n_oe_n,
  input wire logic              drive_reduced,
  input wire logic              dll_locked
);
  // ---------------------------------------------------------------
  // Shadow of loaded fields
  // ---------------------------------------------------------------
  logic        mr_ld;
  logic        er_ld;
  logic        st;
  logic [2:0]  cl_q;
  logic [2:0]  al_q;
  logic [3:0]  ext_q;
  logic [1:0]  age_q;
  logic [7:0]  lock_q;
  logic [15:0] rd_q;
  assign mr_ld = cmd == dmc_pkg::DMC_LOAD && bank == dmc_pkg::BANK_MODE
                 && !addr[7];
  assign er_ld = cmd == dmc_pkg::DMC_LOAD && bank == dmc_pkg::BANK_EXT;
  // Read, strobe and drive outputs are judged only once a load has had time to settle; dll_locked is judged at any time
  assign st = age_q == 2'h3;
  always_ff @(posedge ref_clk_i)
    if (reset_i)
      cl_q <= dmc_pkg::RST_CL;
    else if (mr_ld)
      cl_q <= addr[6:4];
  always_ff @(posedge ref_clk_i)
    if (reset_i)
    begin
      al_q  <= 3'h0;
      ext_q <= 4'h0;
    end
    else if (er_ld)
    begin
      al_q  <= addr[5:3];
      ext_q <= {addr[12:10], addr[1]};
    end
  always_ff @(posedge ref_clk_i)
    if (reset_i || mr_ld || er_ld)
      age_q <= 2'h0;
    else if (!st)
      age_q <= age_q + 2'h1;
  // The DLL counts as settled straight out of reset
  always_ff @(posedge ref_clk_i)
    if (reset_i)
      lock_q <= 8'hff;
    else if ((mr_ld && addr[8]) || cmd == dmc_pkg::DMC_SREX)
      lock_q <= 8'h0;
    else if (lock_q != 8'hff)
      lock_q <= lock_q + 8'h1;
  always_ff @(posedge ref_clk_i)
    if (reset_i)
      rd_q <= 16'h0;
    else
      rd_q <= {rd_q[14:0], cmd == dmc_pkg::DMC_READ};
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  read_latency_a: assert property (st |-> rd_data_valid ==
    rd_q[4'(al_q) + 4'(cl_q)]) else $error("read latency wrong");
  out_disable_a: assert property (st && ext_q[3] |-> dq_oe_n &&
    dqs_oe_n && dqs_n_oe_n && rdqs_oe_n && rdqs_n_oe_n)
    else $error("outputs not disabled");
  single_strobe_a: assert property (st && ext_q[1] |->
    dqs_n_oe_n && rdqs_n_oe_n) else $error("complement strobe driven");
  rdqs_comp_a: assert property (st && !rdqs_n_oe_n |->
    ext_q[2] && !ext_q[1]) else $error("redundant complement driven");
  rdqs_follow_a: assert property (st && ext_q[2] |->
    rdqs_oe_n == dqs_oe_n) else $error("redundant strobe differs");
  rdqs_off_a: assert property (st && !ext_q[2] |-> rdqs_oe_n)
    else $error("redundant strobe driven while off");
  drive_level_a: assert property (st |-> drive_reduced == ext_q[0])
    else $error("drive strength wrong");
  dll_wait_a: assert property ($rose(dll_locked) |-> lock_q >= 8'hc7)
    else $error("lock too early");
  mode_test_a: assert property (cmd == dmc_pkg::DMC_LOAD &&
    bank == dmc_pkg::BANK_MODE |-> !addr[7])
    else $error("test mode programmed");
  read_wait_a: assert property (cmd == dmc_pkg::DMC_READ |->
    lock_q >= 8'hc7) else $error("read too soon after DLL reset");
  sr_dll_off_a: assert property (cmd == dmc_pkg::DMC_SREN |->
    ##[1:4] !dll_locked) else $error("lock kept in self refresh");
endmodule // dmc_assertions

// ---- verification/ddr2_mode_config_decode_bench.sv ----
`timescale 1ns/1ps
module ddr2_mode_config_decode_bench;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        ref_clk_i;
  logic        reset_i;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [15:0] sw_rdata;
  logic [15:0] rd;
  logic [2:0]  rl_cl;
  logic [2:0]  rl_al;
  logic [2:0]  wr_f;
  logic [3:0]  wl;
  logic        pdx;
  logic        dll_run;
  logic        frozen;
  logic        dll_rst;
  logic        tmode;
  logic        dll_en;
  logic        pre_pulse;
  logic [4:0]  oe_at_rd;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t_rd = -100;
  int          t_ap = -100;
  int          d_rd;
  int          d_ap;
  int          t_rf = -100;
  int          d_pa;
  logic [15:0] ext [3] = '{16'h0813, 16'h0c11, 16'h1813};
  logic [4:0]  oe_exp [3] = '{5'h00, 5'h05, 5'h1f};
  logic [15:0] pd_mr [3] = '{16'h1650, 16'h1650, 16'h0650};
  logic [1:0]  pd_v [3] = '{2'h1, 2'h2, 2'h1};
  logic        fz_exp [3] = '{1'b1, 1'b0, 1'b0};
  dmc_if bus ();
  dmc_ctrl dmc_ctrl_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus(bus), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata));
  dmc_mem dmc_mem_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus(bus), .read_latency_o(rl_cl), .additive_latency_o(rl_al),
    .total_write_latency_o(wl), .write_recovery_field_o(wr_f),
    .powerdown_exit_select_o(pdx), .dll_enable_bit_o(dll_en),
    .dll_running_o(dll_run), .dll_frozen_o(frozen),
    .dll_reset_bit_o(dll_rst), .test_mode_o(tmode),
    .precharge_pulse_o(pre_pulse));
  dmc_assertions dmc_assertions_i (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .cmd(bus.cmd), .addr(bus.addr), .bank(bus.bank),
    .rd_data_valid(bus.rd_data_valid), .dq_oe_n(bus.dq_oe_n),
    .dqs_oe_n(bus.dqs_oe_n), .dqs_n_oe_n(bus.dqs_n_oe_n),
    .rdqs_oe_n(bus.rdqs_oe_n), .rdqs_n_oe_n(bus.rdqs_n_oe_n),
    .drive_reduced(bus.drive_reduced), .dll_locked(bus.dll_locked));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ---------------------------------------------------------------
  // Tasks and latency watch
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge ref_clk_i);
    sw_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge ref_clk_i);
    sw_rd <= 1'b0;
    @(negedge ref_clk_i);
    d = sw_rdata;
  endtask
  // Command register write, then room for the load spacing
  task automatic cmd(input logic [15:0] c);
    wr(4'h2, c);
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  always @(negedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (bus.cmd === dmc_pkg::DMC_READ)
      t_rd = cyc;
    if (bus.cmd === dmc_pkg::DMC_WRAP)
      t_ap = cyc;
    if (bus.cmd === dmc_pkg::DMC_REF)
      t_rf = cyc;
    if (bus.cmd === dmc_pkg::DMC_PREA)
      d_pa = cyc - t_rf;
    if (bus.rd_data_valid === 1'b1)
      d_rd = cyc - t_rd;
    if (cyc - t_rd == 8)
      oe_at_rd = {bus.dq_oe_n, bus.dqs_oe_n, bus.dqs_n_oe_n,
                  bus.rdqs_oe_n, bus.rdqs_n_oe_n};
    if (pre_pulse === 1'b1)
      d_ap = cyc - t_ap;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    check(16'({rl_cl, wr_f, rl_al}), 16'({dmc_pkg::RST_CL,
      dmc_pkg::RST_WR, 3'h0}));
    $display("test 1 done");
    wr(4'h0, 16'h1750);
    wr(4'h9, 16'h0000);
    rdr(4'h0, rd);
    check(rd, 16'h1750);
    cmd(16'h0001);
    check(16'({rl_cl, wr_f, pdx, dll_rst, wl}),
      16'({3'h5, 3'h3, 1'b1, 1'b0, 4'h4}));
    repeat (100) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(16'(bus.dll_locked), 16'h0000);
    repeat (110) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(16'(bus.dll_locked), 16'h0001);
    $display("test 2 done");
    // Controller strips the test bit and loads the rest
    wr(4'h0, 16'h06c0);
    rdr(4'h0, rd);
    check(rd, 16'h0640);
    cmd(16'h0001);
    check(16'({rl_cl, tmode}), 16'({3'h4, 1'b0}));
    for (int i = 0; i < 3; i++)
    begin
      cmd(16'h0000);
      wr(4'h0, pd_mr[i]);
      cmd(16'h0001);
      cmd(16'({pd_v[i], 4'h0}));
      check(16'({tmode, frozen, dll_run}),
        16'({1'b0, fz_exp[i], !fz_exp[i]}));
    end
    cmd(16'h0000);
    $display("test 3 done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h1, ext[i]);
      cmd(16'h0002);
      check(16'({rl_al, wl, bus.drive_reduced}),
        16'({3'h2, 4'h6, ext[i][1]}));
      d_rd = -1;
      cmd(16'h0003);
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      // Read is seen half a cycle before its edge: RL plus one
      check(16'(d_rd), 16'h0008);
      check(16'(oe_at_rd), 16'(oe_exp[i]));
    end
    $display("test 4 done");
    d_ap = -1;
    cmd(16'h0004);
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(16'(d_ap), 16'h000d);
    wr(4'h0, 16'h0050);
    cmd(16'h0001);
    rdr(4'h3, rd);
    check(16'({rd[4], wr_f, rl_al}), 16'({1'b1, 3'h3, 3'h2}));
    $display("test 5 done");
    cmd(16'h0006);
    check(16'({dll_run, bus.dll_locked}), 16'h0000);
    cmd(16'h0007);
    check(16'({dll_run, bus.dll_locked}), 16'h0002);
    repeat (210) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(16'(bus.dll_locked), 16'h0001);
    $display("test 6 done");
    d_pa = -1;
    cmd(16'h0005);
    check(16'(d_pa), 16'hffff);
    wr(4'h1, 16'h0010);
    cmd(16'h0002);
    check(16'({dll_en, bus.dll_locked}), 16'h0000);
    d_pa = -1;
    cmd(16'h0005);
    check(16'(d_pa), 16'h0001);
    $display("test 7 done");
    end_sim();
  end
endmodule // ddr2_mode_config_decode_bench
